// >>> design/spw_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module spw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage only feeds the second stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : spw_sync

// >>> design/spw_top.sv
// strap capture, eeprom pin muxing and wake signalling
`timescale 1ns/1ps
//
// Contract
// - eeprom data pin drives and samples the serial eeprom data line
// - data pin may be output three or tx monitor; select held inactive
// - clock pin may be output four or rx monitor; select held inactive
// - speed strap latched at reset release sets default link settings
// - strap 0 gives 10M half no aneg; strap 1 gives 100M half aneg
// - low reset input returns all logic to its reset state
// - floating reset relies on internal power-on reset; pull-up keeps high
// - enabled wake event while asleep drives wake output with programmable polarity
// - wake event does not wake device; only host write cycle does
module spw_top (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       mii_clk_i,
  input  wire logic [1:0] data_fn_sel_i,
  input  wire logic [1:0] clk_fn_sel_i,
  input  wire logic       general_output_three_i,
  input  wire logic       general_output_four_i,
  input  wire logic       eeprom_select_req_i,
  input  wire logic       eeprom_serial_clock_req_i,
  input  wire logic       eeprom_data_out_i,
  input  wire logic       eeprom_data_drive_i,
  input  wire logic       mii_tx_en_i,
  input  wire logic       mii_rx_dv_i,
  input  wire logic       eeprom_data_io_i,
  input  wire logic       speed_strap_i,
  input  wire logic       chip_select_low_i,
  input  wire logic       write_strobe_low_i,
  input  wire logic       read_strobe_low_i,
  input  wire logic       sleep_req_i,
  input  wire logic       wake_event_i,
  input  wire logic       wake_enable_i,
  input  wire logic       wake_polarity_i,
  output logic            eeprom_data_io_o,
  output logic            eeprom_data_io_oe_n_o,
  output logic            eeprom_data_in_o,
  output logic            eeprom_serial_clock_o,
  output logic            eeprom_select_o,
  output logic            bus_width_32_o,
  output logic            speed_100_o,
  output logic            full_duplex_o,
  output logic            aneg_enable_o,
  output logic            wake_event_out_o,
  output logic            asleep_o,
  output logic            write_enabled_o
);

  // ----------------------------------------------------------------
  // reset release marker and strap capture
  // ----------------------------------------------------------------
  // the reset pin pull-up and power-on reset sit in the pad ring, so a
  // floating pin simply arrives here as a high level
  logic strap_done;
  logic strap_bus;
  logic strap_speed;
  logic data_pin_sync;
  logic speed_sync;

  spw_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({eeprom_data_io_i, speed_strap_i}),
    .q_o       ({data_pin_sync, speed_sync})
  );

  // straps are caught by the clock after release, never loaded by the reset;
  // the sync pipe is waited out so the captured level is the real pin level
  logic [1:0] release_cnt;
  wire        release_ready = (release_cnt == 2'h2);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      release_cnt <= 2'h0;
      strap_done  <= 1'b0;
      strap_bus   <= spw_pkg::STRAP_RESET;
      strap_speed <= spw_pkg::STRAP_RESET;
    end else if (!strap_done) begin
      release_cnt <= release_ready ? release_cnt : release_cnt + 2'h1;
      if (release_ready) begin
        strap_done  <= 1'b1;
        strap_bus   <= data_pin_sync;
        strap_speed <= speed_sync;
      end
    end
  end

  // link defaults from the speed strap, bus width from the data pin strap
  wire next_speed_100 = strap_speed ? spw_pkg::SPEED_100 : spw_pkg::SPEED_10;
  wire next_aneg      = strap_speed ? spw_pkg::ANEG_ON : spw_pkg::ANEG_OFF;
  wire next_bus_32    = strap_bus ? spw_pkg::BUS_32 : spw_pkg::BUS_16;

  // ----------------------------------------------------------------
  // mii monitor crossing
  // ----------------------------------------------------------------
  // the monitored clock is divided by two on its own domain; a level toggle
  // crosses cleanly, at the cost of showing half the mii clock rate
  logic mii_clk_div;
  logic mii_tx_en_l;
  logic mii_rx_dv_l;

  always_ff @(posedge mii_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mii_clk_div <= 1'b0;
      mii_tx_en_l <= 1'b0;
      mii_rx_dv_l <= 1'b0;
    end else begin
      mii_clk_div <= ~mii_clk_div;
      mii_tx_en_l <= mii_tx_en_i;
      mii_rx_dv_l <= mii_rx_dv_i;
    end
  end

  logic mon_clk;
  logic mon_tx_en;
  logic mon_rx_dv;

  spw_sync #(.WIDTH(3)) u_mii_sync (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({mii_clk_div, mii_tx_en_l, mii_rx_dv_l}),
    .q_o       ({mon_clk, mon_tx_en, mon_rx_dv})
  );

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  // selections are ignored until the straps are taken, so the data pin is an
  // input while its strap level is sampled
  logic [1:0] data_fn;
  logic [1:0] clk_fn;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_fn <= spw_pkg::FN_RESET;
      clk_fn  <= spw_pkg::FN_RESET;
    end else if (strap_done) begin
      data_fn <= data_fn_sel_i;
      clk_fn  <= clk_fn_sel_i;
    end
  end

  wire data_is_ee = (data_fn == spw_pkg::SPW_FN_EEPROM);
  wire clk_is_ee  = (clk_fn == spw_pkg::SPW_FN_EEPROM);

  // data pin source per function
  wire next_data_out =
      (data_fn == spw_pkg::SPW_FN_GPO)     ? general_output_three_i :
      (data_fn == spw_pkg::SPW_FN_MON_A)   ? mon_tx_en :
      (data_fn == spw_pkg::SPW_FN_MON_CLK) ? mon_clk :
                                             eeprom_data_out_i;
  // reassigned pin is always driven, eeprom pin only when asked
  wire next_data_oe_n = data_is_ee ? ~(eeprom_data_drive_i && strap_done) : 1'b0;

  // clock pin source per function
  wire next_clk_out =
      (clk_fn == spw_pkg::SPW_FN_GPO)     ? general_output_four_i :
      (clk_fn == spw_pkg::SPW_FN_MON_A)   ? mon_rx_dv :
      (clk_fn == spw_pkg::SPW_FN_MON_CLK) ? mon_clk :
                                            eeprom_serial_clock_req_i;

  // select stays low unless both pins serve the eeprom and the straps are
  // taken, so the eeprom can never pull the data pin while its level is caught
  wire next_select = eeprom_select_req_i && data_is_ee && clk_is_ee &&
                     strap_done;
  // input path only while the pin is in its eeprom role
  wire next_data_in = data_is_ee ? data_pin_sync : 1'b0;

  // ----------------------------------------------------------------
  // host write qualification and power state
  // ----------------------------------------------------------------
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;

  spw_sync #(.WIDTH(3)) u_host_sync (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({chip_select_low_i, write_strobe_low_i, read_strobe_low_i}),
    .q_o       ({cs_n_s, wr_n_s, rd_n_s})
  );

  logic wr_cycle_d;
  wire  wr_cycle   = ~cs_n_s && ~wr_n_s;
  wire  rd_cycle   = ~cs_n_s && ~rd_n_s;
  wire  wr_start   = wr_cycle && !wr_cycle_d;

  spw_pkg::spw_pwr_e pwr_state;
  spw_pkg::spw_pwr_e next_pwr_state;
  logic              wr_ok;
  logic              wake_pend;

  // power state machine; a wake event alone never leaves sleep
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      spw_pkg::SPW_AWAKE: begin
        if (sleep_req_i && strap_done) begin
          next_pwr_state = spw_pkg::SPW_SLEEP;
        end
      end
      spw_pkg::SPW_SLEEP: begin
        if (wr_start) begin
          next_pwr_state = spw_pkg::SPW_AWAKE;
        end
      end
      default: next_pwr_state = spw_pkg::SPW_AWAKE;
    endcase
  end

  wire enter_sleep = (pwr_state == spw_pkg::SPW_AWAKE) &&
                     (next_pwr_state == spw_pkg::SPW_SLEEP);
  wire leave_sleep = (pwr_state == spw_pkg::SPW_SLEEP) &&
                     (next_pwr_state == spw_pkg::SPW_AWAKE);
  // writes stay blocked until a read follows reset or wake; a read in the
  // same cycle as sleep entry loses, since sleep must re-arm the block
  wire next_wr_ok = enter_sleep || leave_sleep ? 1'b0 :
                    (rd_cycle && strap_done) ? 1'b1 : wr_ok;

  // wake event latched while asleep; set wins over a clearing wake
  wire ev_set     = wake_event_i && wake_enable_i && (pwr_state == spw_pkg::SPW_SLEEP);
  wire next_pend  = ev_set ? 1'b1 : (leave_sleep || !wake_enable_i) ? 1'b0 : wake_pend;
  wire next_wake  = next_pend ^ ~wake_polarity_i;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_state  <= spw_pkg::SPW_AWAKE;
      wr_cycle_d <= 1'b0;
      wr_ok      <= 1'b0;
      wake_pend  <= 1'b0;
    end else begin
      pwr_state  <= next_pwr_state;
      wr_cycle_d <= wr_cycle;
      wr_ok      <= next_wr_ok;
      wake_pend  <= next_pend;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eeprom_data_io_o      <= 1'b0;
      eeprom_data_io_oe_n_o <= 1'b1;
      eeprom_data_in_o      <= 1'b0;
      eeprom_serial_clock_o <= 1'b0;
      eeprom_select_o       <= 1'b0;
      bus_width_32_o        <= spw_pkg::BUS_16;
      speed_100_o           <= spw_pkg::SPEED_10;
      full_duplex_o         <= spw_pkg::DUPLEX_HALF;
      aneg_enable_o         <= spw_pkg::ANEG_OFF;
      wake_event_out_o      <= 1'b0;
      asleep_o              <= 1'b0;
      write_enabled_o       <= 1'b0;
    end else begin
      eeprom_data_io_o      <= next_data_out;
      eeprom_data_io_oe_n_o <= next_data_oe_n;
      eeprom_data_in_o      <= next_data_in;
      eeprom_serial_clock_o <= next_clk_out;
      eeprom_select_o       <= next_select;
      bus_width_32_o        <= next_bus_32;
      speed_100_o           <= next_speed_100;
      full_duplex_o         <= spw_pkg::DUPLEX_HALF;
      aneg_enable_o         <= next_aneg;
      wake_event_out_o      <= next_wake;
      asleep_o              <= (next_pwr_state == spw_pkg::SPW_SLEEP);
      write_enabled_o       <= next_wr_ok;
    end
  end

endmodule : spw_top

// >>> pkg/spw_pkg.sv
// shared constants for the strap, pin mux and wake control block
package spw_pkg;

  // ----------------------------------------------------------------
  // pin function selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPW_FN_EEPROM  = 2'h0,
    SPW_FN_GPO     = 2'h1,
    SPW_FN_MON_A   = 2'h2,
    SPW_FN_MON_CLK = 2'h3
  } spw_fn_e;

  // ----------------------------------------------------------------
  // reset values and strap decode
  // ----------------------------------------------------------------
  localparam logic [1:0] FN_RESET         = 2'h0;
  localparam logic       STRAP_RESET      = 1'h0;
  localparam logic       SPEED_10         = 1'h0;
  localparam logic       SPEED_100        = 1'h1;
  localparam logic       DUPLEX_HALF      = 1'h0;
  localparam logic       ANEG_OFF         = 1'h0;
  localparam logic       ANEG_ON          = 1'h1;
  localparam logic       BUS_16           = 1'h0;
  localparam logic       BUS_32           = 1'h1;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SPW_AWAKE = 1'h0,
    SPW_SLEEP = 1'h1
  } spw_pwr_e;

endpackage : spw_pkg

// >>> tb/spw_eeprom_model.sv
// serial eeprom data line model with board pull level
`timescale 1ns/1ps
module spw_eeprom_model (
  input  wire logic select_i,
  input  wire logic sclk_i,
  input  wire logic dev_oe_n_i,
  input  wire logic dev_data_i,
  input  wire logic pull_i,
  output logic      pin_o
);
  // ----------------------------------------------------------------
  // data line
  // ----------------------------------------------------------------
  logic bit_q = 1'b0;
  // pattern changes each clock so a stale sample never matches by luck
  always @(posedge sclk_i) if (select_i) bit_q <= ~bit_q;
  assign pin_o = !dev_oe_n_i ? dev_data_i : (select_i ? bit_q : pull_i); // pull when released and not selected
endmodule : spw_eeprom_model

// >>> tb/spw_top_bench.sv
// self-checking bench for the strap, pin mux and wake block
`timescale 1ns/1ps
`define CHECK(what, got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", what, exp, got); end end
module spw_top_bench;
  logic       ref_clk_i = 1'b0, reset_n_i = 1'b0, mii_clk_i = 1'b0, pull_level = 1'b0;
  logic [1:0] data_fn_sel_i = 2'h0, clk_fn_sel_i = 2'h0;
  logic       general_output_three_i = 1'b0, general_output_four_i = 1'b0;
  logic       eeprom_select_req_i = 1'b0, eeprom_serial_clock_req_i = 1'b0;
  logic       eeprom_data_out_i = 1'b0, eeprom_data_drive_i = 1'b0, speed_strap_i = 1'b0;
  logic       mii_tx_en_i = 1'b0, mii_rx_dv_i = 1'b0, sleep_req_i = 1'b0;
  logic       chip_select_low_i = 1'b1, write_strobe_low_i = 1'b1, read_strobe_low_i = 1'b1;
  logic       wake_event_i = 1'b0, wake_enable_i = 1'b0, wake_polarity_i = 1'b0;
  wire        eeprom_data_io_i;
  logic       eeprom_data_io_o, eeprom_data_io_oe_n_o, eeprom_data_in_o, eeprom_serial_clock_o;
  logic       eeprom_select_o, bus_width_32_o, speed_100_o, full_duplex_o, aneg_enable_o;
  logic       wake_event_out_o, asleep_o, write_enabled_o, pd, pc;
  int         num_errors = 0, tests_run = 0, cycles = 0, fd, fc;
  // ----------------------------------------------------------------
  // clocks, design and far side
  // ----------------------------------------------------------------
  always #5 ref_clk_i = ~ref_clk_i;
  initial begin
    #3.3;
    forever #6 mii_clk_i = ~mii_clk_i; // offset keeps the link clock out of phase
  end
  spw_top spw_top_i (.*);
  spw_eeprom_model spw_eeprom_model_i (.select_i(eeprom_select_o), .sclk_i(eeprom_serial_clock_o),
    .dev_oe_n_i(eeprom_data_io_oe_n_o), .dev_data_i(eeprom_data_io_o), .pull_i(pull_level),
    .pin_o(eeprom_data_io_i));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // run is under two hundred cycles, so this only trips on a hang
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic rst(input logic lvl, input logic spd);
    reset_n_i = 1'b0;
    pull_level = lvl;
    speed_strap_i = spd;
    cyc(12);
    `CHECK("oe_n in reset", eeprom_data_io_oe_n_o, 1'b1)
    `CHECK("asleep in reset", asleep_o, 1'b0)
    reset_n_i = 1'b1;
    cyc(6);
    `CHECK("bus width", bus_width_32_o, lvl)
    `CHECK("speed", speed_100_o, spd)
    `CHECK("aneg", aneg_enable_o, spd)
    `CHECK("duplex", full_duplex_o, 1'b0)
  endtask : rst
  // strobes held well past the sync so the cycle is never missed
  task automatic host(input logic wr);
    chip_select_low_i = 1'b0;
    write_strobe_low_i = !wr;
    read_strobe_low_i = wr;
    cyc(6);
    chip_select_low_i = 1'b1;
    write_strobe_low_i = 1'b1;
    read_strobe_low_i = 1'b1;
    cyc(3);
  endtask : host
  task automatic link(input logic v);
    @(posedge mii_clk_i);
    #1;
    mii_tx_en_i = v;
    mii_rx_dv_i = !v;
    cyc(8);
    `CHECK("tx monitor", eeprom_data_io_o, v)
    `CHECK("rx monitor", eeprom_serial_clock_o, !v)
  endtask : link
  task automatic sleep;
    sleep_req_i = 1'b1;
    cyc(1);
    sleep_req_i = 1'b0;
    cyc(2);
  endtask : sleep
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst(1'b1, 1'b1);
    eeprom_select_req_i = 1'b1;
    eeprom_data_drive_i = 1'b1;
    cyc(4);
    `CHECK("select", eeprom_select_o, 1'b1)
    `CHECK("data oe_n", eeprom_data_io_oe_n_o, 1'b0)
    `CHECK("data out", eeprom_data_io_o, 1'b0)
    eeprom_data_drive_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      eeprom_serial_clock_req_i = i[0];
      cyc(5);
      `CHECK("clock", eeprom_serial_clock_o, i[0])
      `CHECK("data in", eeprom_data_in_o, eeprom_data_io_i)
    end
    for (int f = 1; f < 4; f++) begin
      data_fn_sel_i = f[1:0];
      clk_fn_sel_i = f[1:0];
      cyc(5);
      `CHECK("select off", eeprom_select_o, 1'b0)
      `CHECK("no input", eeprom_data_in_o, 1'b0)
      `CHECK("pin driven", eeprom_data_io_oe_n_o, 1'b0)
      for (int v = 0; v < 2 && f == 1; v++) begin
        general_output_three_i = v[0];
        general_output_four_i = !v[0];
        cyc(4);
        `CHECK("gpo three", eeprom_data_io_o, v[0])
        `CHECK("gpo four", eeprom_serial_clock_o, !v[0])
      end
      if (f == 2) link(1'b1);
      if (f == 2) link(1'b0);
    end
    fd = 0;
    fc = 0;
    for (int k = 0; k < 24; k++) begin
      pd = eeprom_data_io_o;
      pc = eeprom_serial_clock_o;
      cyc(1);
      if (eeprom_data_io_o !== pd) fd++;
      if (eeprom_serial_clock_o !== pc) fc++;
    end
    `CHECK("tx clock monitor", fd >= 10, 1'b1)
    `CHECK("rx clock monitor", fc >= 10, 1'b1)
    data_fn_sel_i = 2'h0;
    clk_fn_sel_i = 2'h0;
    host(1'b1);
    `CHECK("write before read", write_enabled_o, 1'b0)
    host(1'b0);
    `CHECK("write after read", write_enabled_o, 1'b1)
    sleep();
    `CHECK("sleep writes off", write_enabled_o, 1'b0)
    host(1'b0);
    `CHECK("read keeps sleep", asleep_o, 1'b1)
    wake_event_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      wake_polarity_i = p[0];
      wake_enable_i = 1'b0;
      cyc(3);
      `CHECK("wake idle", wake_event_out_o, !p[0])
      wake_enable_i = 1'b1;
      cyc(3);
      `CHECK("wake active", wake_event_out_o, p[0])
      `CHECK("event keeps sleep", asleep_o, 1'b1)
    end
    wake_event_i = 1'b0;
    host(1'b1);
    `CHECK("write wakes", asleep_o, 1'b0)
    `CHECK("wake cleared", wake_event_out_o, 1'b0)
    `CHECK("read needed again", write_enabled_o, 1'b0)
    sleep();
    rst(1'b0, 1'b0);
    stop_test();
  end
endmodule : spw_top_bench
bind spw_top spw_top_chk spw_top_chk_i (.*);

// >>> tb/spw_top_chk.sv
// concurrent checks on the strap, pin mux and wake block ports
`timescale 1ns/1ps
module spw_top_chk (
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  input wire logic [1:0] data_fn_sel_i,
  input wire logic [1:0] clk_fn_sel_i,
  input wire logic       general_output_three_i,
  input wire logic       chip_select_low_i,
  input wire logic       write_strobe_low_i,
  input wire logic       read_strobe_low_i,
  input wire logic       wake_enable_i,
  input wire logic       wake_polarity_i,
  input wire logic       eeprom_data_io_o,
  input wire logic       eeprom_data_io_oe_n_o,
  input wire logic       eeprom_select_o,
  input wire logic       bus_width_32_o,
  input wire logic       speed_100_o,
  input wire logic       full_duplex_o,
  input wire logic       aneg_enable_o,
  input wire logic       wake_event_out_o,
  input wire logic       asleep_o,
  input wire logic       write_enabled_o
);
  // ----------------------------------------------------------------
  // settle counter and checks
  // ----------------------------------------------------------------
  logic [3:0] rel_cnt;
  logic       settled;
  assign settled = (rel_cnt == 4'hF); // straps and roles long since taken
  // counts edges after reset release, so early strap traffic is not judged
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rel_cnt <= 4'h0;
    else if (!settled) rel_cnt <= rel_cnt + 4'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_data_role_sel: assert property (
    (settled && data_fn_sel_i != 2'h0)[*3] |=> !eeprom_select_o)
    else $error("select active in data pin role");
  chk_clk_role_sel: assert property (
    (settled && clk_fn_sel_i != 2'h0)[*3] |=> !eeprom_select_o)
    else $error("select active in clock pin role");
  // the pin shows the value taken one edge earlier, so compare with the past
  chk_gpo_three_val: assert property ((settled && data_fn_sel_i == 2'h1
    && $stable(general_output_three_i))[*3] |=> !eeprom_data_io_oe_n_o
    && eeprom_data_io_o == $past(general_output_three_i))
    else $error("data pin not output three");
  chk_default_link: assert property (!full_duplex_o && aneg_enable_o == speed_100_o)
    else $error("default link settings wrong");
  chk_strap_hold: assert property (
    settled |=> $stable(bus_width_32_o) && $stable(speed_100_o))
    else $error("strap value moved after release");
  chk_wake_by_write: assert property (settled && $fell(asleep_o) |->
    $past(!chip_select_low_i && !write_strobe_low_i, 3)) else $error("woke without write");
  chk_read_before_wr: assert property (settled && $rose(write_enabled_o) |->
    $past(!chip_select_low_i && !read_strobe_low_i, 2)) else $error("writes on without read");
  chk_wake_idle_lvl: assert property (
    (settled && !wake_enable_i && $stable(wake_polarity_i))[*3]
    |=> wake_event_out_o == !$past(wake_polarity_i))
    else $error("wake output active when off");
  cov_wake_exit: cover property (settled && $fell(asleep_o));
  cov_wake_out: cover property (asleep_o && wake_enable_i && wake_event_out_o == wake_polarity_i);
  cov_clk_monitor: cover property (settled && data_fn_sel_i == 2'h3);
endmodule : spw_top_chk
